// *** verilog/rrl_exec.sv ***
// Execution unit for return-from-interrupt and rotate-accumulator-left.
`timescale 1ns/1ns
// What this block does
// RULE_01 - Pop high program counter byte, then low
// RULE_02 - Stack pointer ends two lower, stepwise
// RULE_03 - Release active priority level to interrupts
// RULE_04 - Only program counter and stack pointer change
// RULE_05 - Fetch resumes at the popped address
// RULE_06 - Pending equal/lower interrupt waits one instruction
// RULE_07 - Rotate accumulator left, bit 7 into 0
// RULE_08 - Rotate leaves all status flags unchanged
module rrl_exec
    import rrl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              op_valid,
    input  wire logic [7:0]        op_code,
    input  wire logic [7:0]        stack_pointer,
    input  wire logic [7:0]        acc_in,
    input  wire logic [7:0]        stack_rdata,
    input  wire logic              int_pending_le,
    input  wire logic              instr_done,
    output rrl_stack_req_type      stack_req_r,
    output rrl_counter_load_type   program_counter_r,
    output logic                   stack_pointer_wr_r,
    output logic [7:0]             stack_pointer_value_r,
    output logic                   acc_wr_r,
    output logic [7:0]             acc_value_r,
    output logic                   program_status_word_wr_r,
    output logic                   prio_release_r,
    output logic                   vector_hold_r,
    output logic                   busy_r,
    output logic                   done_r
);

    rrl_state_type state_r;
    logic [7:0]    ptr_work_r;
    logic [7:0]    hi_byte_r;
    logic          take_return;
    logic          take_rotate;

    assign take_return = op_valid && !busy_r && (op_code == RRL_OP_RETURN);
    assign take_rotate = op_valid && !busy_r && (op_code == RRL_OP_ROTATE);

    // Sequencer for the two stack reads; the stack RAM answers one cycle after rd.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r     <= RRL_IDLE;
            busy_r      <= 1'b0;
            stack_req_r <= '0;
            ptr_work_r  <= RRL_BYTE_RESET;
            hi_byte_r   <= RRL_BYTE_RESET;
        end else begin
            unique case (state_r)
                RRL_IDLE: begin
                    if (take_return) begin
                        state_r          <= RRL_RD_HI;
                        busy_r           <= 1'b1;
                        stack_req_r.rd   <= 1'b1; // RULE_01
                        stack_req_r.addr <= stack_pointer;
                        ptr_work_r       <= stack_pointer - RRL_PTR_STEP;
                    end
                end
                RRL_RD_HI: begin
                    state_r          <= RRL_RD_LO;
                    stack_req_r.rd   <= 1'b1; // RULE_01
                    stack_req_r.addr <= ptr_work_r;
                    ptr_work_r       <= ptr_work_r - RRL_PTR_STEP;
                end
                RRL_RD_LO: begin
                    state_r        <= RRL_FIN;
                    stack_req_r.rd <= 1'b0;
                    hi_byte_r      <= stack_rdata; // RULE_01
                end
                RRL_FIN: begin
                    state_r <= RRL_IDLE;
                    busy_r  <= 1'b0;
                end
            endcase
        end
    end

    // Stack pointer is written back once after each byte read.
    always_ff @(posedge clk) begin
        if (rst) begin
            stack_pointer_wr_r    <= 1'b0;
            stack_pointer_value_r <= RRL_BYTE_RESET;
        end else begin
            stack_pointer_wr_r <= (state_r == RRL_RD_HI) || (state_r == RRL_RD_LO); // RULE_02
            if ((state_r == RRL_RD_HI) || (state_r == RRL_RD_LO)) begin
                stack_pointer_value_r <= ptr_work_r; // RULE_02
            end
        end
    end

    // Program counter load, priority release and completion.
    always_ff @(posedge clk) begin
        if (rst) begin
            program_counter_r <= '{load: 1'b0, value: RRL_COUNTER_RESET};
            prio_release_r    <= 1'b0;
            done_r            <= 1'b0;
        end else begin
            program_counter_r.load <= (state_r == RRL_FIN); // RULE_05
            prio_release_r         <= (state_r == RRL_FIN); // RULE_03
            done_r                 <= (state_r == RRL_FIN) || take_rotate;
            if (state_r == RRL_FIN) begin
                program_counter_r.value <= {hi_byte_r, stack_rdata}; // RULE_01
            end
        end
    end

    // Holding off the vector until one more instruction completes; setting wins over clearing.
    always_ff @(posedge clk) begin
        if (rst) begin
            vector_hold_r <= 1'b0;
        end else if ((state_r == RRL_FIN) && int_pending_le) begin
            vector_hold_r <= 1'b1; // RULE_06
        end else if (instr_done) begin
            vector_hold_r <= 1'b0; // RULE_06
        end
    end

    // Accumulator path; the status word is never written by either instruction.
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_wr_r    <= 1'b0;
            acc_value_r <= RRL_BYTE_RESET;
            program_status_word_wr_r <= 1'b0;
        end else begin
            acc_wr_r                 <= take_rotate;
            program_status_word_wr_r <= 1'b0; // RULE_04 RULE_08
            if (take_rotate) begin
                acc_value_r <= {acc_in[6:0], acc_in[7]}; // RULE_07
            end
        end
    end

    sequence s_return_start;
        op_valid && !busy_r && (op_code == RRL_OP_RETURN);
    endsequence

    sequence s_rotate_start;
        op_valid && !busy_r && (op_code == RRL_OP_ROTATE);
    endsequence

    sequence s_two_reads;
        (stack_req_r.rd && stack_req_r.addr == $past(stack_pointer))
        ##1 (stack_req_r.rd && stack_req_r.addr == $past(stack_pointer, 2) - RRL_PTR_STEP);
    endsequence

    property p_read_order;
        @(posedge clk) disable iff (rst)
        s_return_start |=> s_two_reads;
    endproperty
    a_read_order: assert property (p_read_order) // RULE_01
        else $error("Stack reads not issued high address first.");

    property p_counter_bytes;
        @(posedge clk) disable iff (rst)
        program_counter_r.load |->
            program_counter_r.value == {$past(stack_rdata, 2), $past(stack_rdata)};
    endproperty
    a_counter_bytes: assert property (p_counter_bytes) // RULE_01
        else $error("Program counter not built from high then low byte.");

    property p_ptr_steps;
        @(posedge clk) disable iff (rst)
        s_return_start |-> ##2 (stack_pointer_wr_r
            && stack_pointer_value_r == $past(stack_pointer, 2) - RRL_PTR_STEP)
            ##1 (stack_pointer_wr_r
            && stack_pointer_value_r == $past(stack_pointer, 3) - RRL_PTR_STEP - RRL_PTR_STEP)
            ##1 !stack_pointer_wr_r;
    endproperty
    a_ptr_steps: assert property (p_ptr_steps) // RULE_02
        else $error("Stack pointer not decremented once per byte.");

    // The previous return may still show its release in the cycle a new one is taken.
    property p_release;
        @(posedge clk) disable iff (rst)
        s_return_start |=> !prio_release_r [*3] ##1 prio_release_r ##1 !prio_release_r;
    endproperty
    a_release: assert property (p_release) // RULE_03
        else $error("Priority release pulse misplaced.");

    property p_only_counter_pointer;
        @(posedge clk) disable iff (rst)
        s_return_start |=> (!acc_wr_r && !program_status_word_wr_r) [*4];
    endproperty
    a_only_counter_pointer: assert property (p_only_counter_pointer) // RULE_04
        else $error("Return wrote a register other than counter and pointer.");

    property p_fetch_resume;
        @(posedge clk) disable iff (rst)
        s_return_start |-> ##4 (program_counter_r.load && done_r && !busy_r);
    endproperty
    a_fetch_resume: assert property (p_fetch_resume) // RULE_05
        else $error("Program counter not loaded at end of return.");

    property p_hold_set;
        @(posedge clk) disable iff (rst)
        program_counter_r.load |-> (vector_hold_r == $past(int_pending_le) || $past(vector_hold_r));
    endproperty
    a_hold_set: assert property (p_hold_set) // RULE_06
        else $error("Vector hold not set for pending interrupt.");

    property p_hold_clear;
        @(posedge clk) disable iff (rst)
        vector_hold_r && instr_done && !(state_r == RRL_FIN && int_pending_le) |=> !vector_hold_r;
    endproperty
    a_hold_clear: assert property (p_hold_clear) // RULE_06
        else $error("Vector hold not released after one instruction.");

    property p_rotate;
        @(posedge clk) disable iff (rst)
        s_rotate_start |=> acc_wr_r && done_r
            && acc_value_r == {$past(acc_in[6:0]), $past(acc_in[7])};
    endproperty
    a_rotate: assert property (p_rotate) // RULE_07
        else $error("Rotate left result wrong.");

    property p_rotate_flags;
        @(posedge clk) disable iff (rst)
        s_rotate_start |=> !program_status_word_wr_r && !stack_pointer_wr_r
            && !program_counter_r.load;
    endproperty
    a_rotate_flags: assert property (p_rotate_flags) // RULE_08
        else $error("Rotate touched status word or other state.");

endmodule // rrl_exec

// *** include/rrl_pkg.sv ***
// Constants and carrier types for the return and rotate execution block.
package rrl_pkg;

    localparam int        RRL_DATA_W      = 8;
    localparam int          RRL_COUNTER_W     = 16;
    localparam logic [7:0]  RRL_OP_RETURN     = 8'h32;
    localparam logic [7:0]  RRL_OP_ROTATE     = 8'h23;
    localparam logic [7:0]  RRL_PTR_STEP      = 8'h01;
    localparam logic [7:0]  RRL_BYTE_RESET    = 8'h00;
    localparam logic [15:0] RRL_COUNTER_RESET = 16'h0000;

    typedef struct packed {
        logic                  rd;
        logic [RRL_DATA_W-1:0] addr;
    } rrl_stack_req_type;

    typedef struct packed {
        logic                     load;
        logic [RRL_COUNTER_W-1:0] value;
    } rrl_counter_load_type;

    typedef enum logic [1:0] {
        RRL_IDLE,
        RRL_RD_HI,
        RRL_RD_LO,
        RRL_FIN
    } rrl_state_type;

endpackage

// *** tb/rrl_stack_model.sv ***
// Stack RAM and interrupt-side model facing the return and rotate block.
`timescale 1ns/1ns
module rrl_stack_model
    import rrl_pkg::*;
(
    input  wire logic              clk,
    input  wire rrl_stack_req_type stack_req,
    input  wire logic              prio_release,
    output logic [7:0]             stack_rdata,
    output int                     release_count
);
    logic [7:0] mem [0:255];
    initial begin
        stack_rdata   = 8'h00;
        release_count = 0;
    end
    // Between reads the data lines flip every cycle, so a late sample cannot pass as good data.
    always @(posedge clk) begin
        if (stack_req.rd) begin
            stack_rdata <= mem[stack_req.addr];
        end else begin
            stack_rdata <= ~stack_rdata;
        end
    end
    always @(posedge clk) begin
        if (prio_release) begin
            release_count <= release_count + 1;
        end
    end
endmodule // rrl_stack_model

// *** tb/tb_top.sv ***
// Self-checking bench for the return and rotate execution block.
`timescale 1ns/1ns
module tb_top;
    import rrl_pkg::*;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 op_valid = 1'b0;
    logic [7:0]           op_code = 8'h00;
    logic [7:0]           stack_pointer = 8'h00;
    logic [7:0]           acc_in = 8'h00;
    logic                 int_pending_le = 1'b0;
    logic                 instr_done = 1'b0;
    logic [7:0]           stack_rdata, stack_pointer_value_r, acc_value_r;
    rrl_stack_req_type    stack_req_r;
    rrl_counter_load_type program_counter_r;
    logic                 stack_pointer_wr_r, acc_wr_r, program_status_word_wr_r;
    logic                 prio_release_r, vector_hold_r, busy_r, done_r;
    logic [3:0]           strobes;
    int                   num_errors = 0;
    int                   comparisons = 0;
    int                   release_count;
    assign strobes = {acc_wr_r, done_r, program_status_word_wr_r, stack_pointer_wr_r};
    always #4 clk = ~clk;
    rrl_exec uut (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .stack_pointer(stack_pointer), .acc_in(acc_in), .stack_rdata(stack_rdata),
        .int_pending_le(int_pending_le), .instr_done(instr_done), .stack_req_r(stack_req_r),
        .program_counter_r(program_counter_r), .stack_pointer_wr_r(stack_pointer_wr_r),
        .stack_pointer_value_r(stack_pointer_value_r), .acc_wr_r(acc_wr_r),
        .acc_value_r(acc_value_r), .program_status_word_wr_r(program_status_word_wr_r),
        .prio_release_r(prio_release_r), .vector_hold_r(vector_hold_r), .busy_r(busy_r),
        .done_r(done_r));
    rrl_stack_model u_stack (.clk(clk), .stack_req(stack_req_r), .prio_release(prio_release_r),
        .stack_rdata(stack_rdata), .release_count(release_count));
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Two rotates issued back to back.
    task automatic test_rotate(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code  <= RRL_OP_ROTATE;
        acc_in   <= a;
        @(posedge clk);
        acc_in <= b;
        #1;
        check({strobes, 5'h00, acc_value_r}, {4'hC, 5'h00, a[6:0], a[7]});
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        check({strobes, 5'h00, acc_value_r}, {4'hC, 5'h00, b[6:0], b[7]});
    endtask
    // A rotate is offered in mid-return and must be ignored.
    task automatic test_return(input logic [7:0] ptr, input logic [15:0] target, input logic pend);
        int          rels;
        int          n_ptr_wr;
        int          nbad;
        logic [15:0] addrs;
        rels     = release_count;
        n_ptr_wr = 0;
        nbad     = 0;
        addrs    = 16'h0000;
        u_stack.mem[ptr] = target[15:8];
        u_stack.mem[ptr - 8'h01] = target[7:0];
        @(posedge clk);
        op_valid       <= 1'b1;
        op_code        <= RRL_OP_RETURN;
        stack_pointer  <= ptr;
        int_pending_le <= pend;
        @(posedge clk);
        op_code <= RRL_OP_ROTATE;
        for (int i = 0; i < 3; i++) begin
            op_valid <= (i == 1);
            #1;
            if (stack_req_r.rd === 1'b1) addrs = {addrs[7:0], stack_req_r.addr};
            if (stack_pointer_wr_r === 1'b1) n_ptr_wr++;
            if (strobes[3:1] !== 3'h0) nbad++;
            @(posedge clk);
        end
        #1;
        check(addrs, {ptr, ptr - 8'h01});
        check(17'(n_ptr_wr), 17'h00002);
        check(stack_pointer_value_r, 8'(ptr - 8'h02));
        check({program_counter_r.load, program_counter_r.value}, {1'b1, target});
        check({prio_release_r, done_r, busy_r, vector_hold_r}, {3'h6, pend});
        check(17'(nbad), 17'h00000);
        @(posedge clk);
        instr_done <= 1'b1;
        #1;
        check({program_counter_r.load, prio_release_r, done_r, vector_hold_r}, {3'h0, pend});
        check(17'(release_count - rels), 17'h00001);
        @(posedge clk);
        instr_done <= 1'b0;
        #1;
        check(vector_hold_r, 1'b0);
    endtask
    // An opcode outside the two handled ones gets no answer.
    task automatic test_unknown;
        int n;
        n = 0;
        @(posedge clk);
        op_valid <= 1'b1;
        op_code  <= 8'h22;
        @(posedge clk);
        op_valid <= 1'b0;
        repeat (4) begin
            #1;
            if (strobes !== 4'h0 || busy_r !== 1'b0 || stack_req_r.rd !== 1'b0) n++;
            @(posedge clk);
        end
        check(17'(n), 17'h00000);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        test_rotate(8'hC5, 8'h80);
        test_rotate(8'h01, 8'hFF);
        test_return(8'h0B, 16'h0123, 1'b1);
        test_return(8'h01, 16'hFE80, 1'b0);
        test_rotate(8'h00, 8'h7F);
        test_unknown;
        close_out;
    end
    // The tests need well under a hundred cycles; this span leaves ample margin.
    initial begin
        #5000;
        num_errors++;
        close_out;
    end
endmodule // tb_top
